// ==== rtl/irq_accept_defs.vh ====
`ifndef IRQ_ACCEPT_DEFS_VH
`define IRQ_ACCEPT_DEFS_VH
// ==========================================================
// Register indices on the plain register port
`define ADDR_EXT_STATUS 4'h0
`define ADDR_EXT_ENABLE 4'h1
`define ADDR_PIN_SELECT 4'h2
`define ADDR_INT_STATUS 4'h3
`define ADDR_INT_ENABLE 4'h4
`define ADDR_DMA_CLAIM 4'h5
`define ADDR_DTU_SELECT 4'h6
`define ADDR_CONTROL 4'h7
`define ADDR_EVT_STATUS 4'h8
`define ADDR_EVT_MASK 4'h9
// ==========================================================
// Field positions
`define CTRL_MASK_BIT 0
`define CTRL_BLOCK_NEXT_BIT 1
`define CTRL_REFUSE_BIT 2
`define CTRL_REQ_BIT 3
`define EVT_TAKEN_BIT 0
`define EVT_DROPPED_BIT 1
`define EVT_SEL_EDGE_BIT 2
`define EVT_NMI_BIT 3
// Internal sources cleared by a transfer-unit access (serial and converter)
`define XFER_CLEAR_SOURCES 8'hf0
// ==========================================================
// Reset values
`define RST_EXT_ENABLE 16'h0000
`define RST_PIN_SELECT 16'h0000
`define RST_INT_ENABLE 8'h00
`define RST_DMA_CLAIM 8'h00
`define RST_DTU_SELECT 8'h00
`define RST_EVT_MASK 4'h0
`define RST_GLOBAL_MASK 1'b1
// ==========================================================
// Vector codes
`define VEC_INT_BASE 5'h10
`define VEC_NMI 5'h18
`define VEC_NONE 5'h1f
// ==========================================================
// Timing, in states of the 8 ns clock
`define CLK_PERIOD_NS 8
`define MASK_DELAY_STATES 2
`define REFUSE_STATES 3
`define MASK_DELAY_CYCLES 2'h2
`define REFUSE_CYCLES 2'h3
`endif

// ==== rtl/pin_sync.v ====
// ==========================================================
// Two-stage synchroniser for asynchronous pin levels
module pin_sync #(
  parameter WIDTH = 33
) (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // pin_sync

// ==== rtl/hold_timer.v ====
// ==========================================================
// Short down counter: busy while counting, done in its last state
module hold_timer (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire load_in,
  input wire [1:0] count_in,
  output wire busy_out,
  output wire done_out
);
  reg [1:0] count;

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= 2'h0;
    end else if (load_in) begin
      count <= count_in;
    end else if (count != 2'h0) begin
      count <= count - 2'h1;
    end
  end

  assign busy_out = (count != 2'h0);
  assign done_out = (count == 2'h1);
endmodule // hold_timer

// ==== rtl/interrupt_acceptance_timing.v ====
// Summary of operation
// - A request raised while an instruction clears its enable is still taken at that end.
// - In that contention a higher-priority pending request wins and the lower one is dropped.
// - Clearing a source flag inside an instruction behaves the same as clearing its enable.
// - A source already masked when its enable or flag is cleared is never taken.
// - Serial and converter sources clear on a transfer-unit access, whatever claim or select say.
// - After a control-register instruction every request, NMI too, waits one instruction.
// - A global mask set by such an instruction becomes valid two states after it ends.
// - Acceptance is refused for three states after such an instruction updates the mask.
// - During a byte-count block move nothing, NMI included, is accepted until it ends.
// - During a word-count block move a request is taken at a transfer break, saving the next PC.
// - Changing the pin select may make an internal edge that sets a pin flag, channels 0 to 15.
// - Pin flags may be set after reset and clear by a read followed by writing 0.
// - A source claimed by a DMA channel neither starts the transfer unit nor interrupts the CPU.
`include "irq_accept_defs.vh"

module interrupt_acceptance_timing (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [15:0] reg_rdata_out,
  input wire [15:0] ext_pin_request_in,
  input wire [15:0] ext_pin_alt_in,
  input wire nmi_pin_in,
  input wire [7:0] int_src_in,
  input wire [7:0] xfer_access_in,
  input wire cpu_insn_end_in,
  input wire cpu_ctrl_insn_in,
  input wire cpu_ctrl_mask_in,
  input wire block_move_byte_count_in,
  input wire block_move_word_count_in,
  input wire cpu_block_break_in,
  input wire cpu_ack_in,
  output reg cpu_irq_req_out,
  output reg [4:0] cpu_irq_vec_out,
  output reg cpu_irq_at_break_out,
  output wire [7:0] dtu_start_out,
  output wire [7:0] dma_start_out,
  output wire irq_out
);

  // ==========================================================
  // Functions
  function [4:0] winner;
    input [24:0] cand;
    integer i;
    begin
      winner = `VEC_NONE;
      for (i = 23; i >= 0; i = i - 1) begin
        if (cand[i]) begin
          winner = i[4:0];
        end
      end
      if (cand[24]) begin
        winner = `VEC_NMI;
      end
    end
  endfunction

  function [24:0] vec_bit;
    input [4:0] vec;
    begin
      vec_bit = 25'h0000001 << vec;
    end
  endfunction

  // Write strobe aimed at one register index
  function wr_hit;
    input strobe;
    input [3:0] addr;
    input [3:0] target;
    begin
      wr_hit = strobe & (addr == target);
    end
  endfunction

  // ==========================================================
  // Registers
  reg [15:0] ext_pin_flag;
  reg [15:0] ext_read_seen;
  reg [15:0] ext_enable;
  reg [15:0] irq_pin_select_reg;
  reg [15:0] pin_select_prev;
  reg [15:0] level_prev;
  reg [7:0] int_flag;
  reg [7:0] int_enable;
  reg [7:0] dma_claims_source;
  reg [7:0] dtu_select;
  reg [3:0] evt_status;
  reg [3:0] evt_mask;
  reg global_mask;
  reg mask_pend;
  reg block_next;
  reg nmi_flag;
  reg nmi_prev;
  reg [24:0] captured;

  wire [32:0] pins_sync;
  wire [15:0] pri_level;
  wire [15:0] alt_level;
  wire nmi_level;
  wire [15:0] sel_level;
  wire [15:0] pin_rise;
  wire sel_edge;
  wire mask_busy;
  wire mask_done;
  wire refuse_busy;
  wire mask_eff;
  wire [24:0] mask_keep;
  wire [7:0] int_usable;
  wire [24:0] live;
  wire [24:0] cand;
  wire [4:0] win_vec;
  wire accept_point;
  wire blocked;
  wire take;
  wire dropped;
  wire nmi_rise;
  wire wr_hit_ext;
  wire [15:0] ext_clear;
  wire [7:0] int_clear;
  wire [3:0] evt_set;
  wire [3:0] evt_clear;

  // ==========================================================
  // Pin synchronisers and edge detection
  pin_sync #(
    .WIDTH(33)
  ) u_pin_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .async_in({nmi_pin_in, ext_pin_alt_in, ext_pin_request_in}),
    .sync_out(pins_sync)
  );

  assign pri_level = pins_sync[15:0];
  assign alt_level = pins_sync[31:16];
  assign nmi_level = pins_sync[32];
  // Selected level moves with the select register, so a change can edge
  assign sel_level = (irq_pin_select_reg & alt_level) | (~irq_pin_select_reg & pri_level);
  // Level history starts low, so a pin already high after reset flags itself
  assign pin_rise = sel_level & ~level_prev;
  assign sel_edge = |(pin_rise & (irq_pin_select_reg ^ pin_select_prev));
  assign nmi_rise = nmi_level & ~nmi_prev;

  // ==========================================================
  // Mask update delay and refusal window
  // Mask delay: done in the last of its two states
  hold_timer u_mask_delay (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .load_in(cpu_ctrl_insn_in & cpu_ctrl_mask_in),
    .count_in(`MASK_DELAY_CYCLES),
    .busy_out(mask_busy),
    .done_out(mask_done)
  );

  // Refusal window: busy for three states after a control instruction
  hold_timer u_refuse (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .load_in(cpu_ctrl_insn_in),
    .count_in(`REFUSE_CYCLES),
    .busy_out(refuse_busy),
    .done_out()
  );

  assign mask_eff = mask_done ? mask_pend : global_mask;

  // ==========================================================
  // Request selection
  assign int_usable = int_flag & int_enable & ~dma_claims_source;
  assign dtu_start_out = int_flag & dtu_select & ~dma_claims_source;
  assign dma_start_out = int_flag & dma_claims_source;
  // Masked sources never enter the capture, so clearing them races nothing
  assign live = {nmi_flag, {int_usable, ext_pin_flag & ext_enable} & {24{~mask_eff}}};
  // NMI ignores the global mask; captured requests obey it like live ones
  assign mask_keep = {1'b1, {24{~mask_eff}}};
  // Requests seen during the instruction survive a clear inside it
  assign cand = (captured & mask_keep) | live;
  assign win_vec = winner(cand);
  assign accept_point = (cpu_insn_end_in & ~block_move_byte_count_in
                        & ~block_move_word_count_in)
                        | (cpu_block_break_in & block_move_word_count_in);
  assign blocked = block_next | cpu_ctrl_insn_in | refuse_busy;
  assign take = accept_point & ~blocked & ~cpu_irq_req_out & (|cand);
  assign dropped = take & (|(cand & ~vec_bit(win_vec)));

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      captured <= 25'h0000000;
    end else if (take) begin
      captured <= 25'h0000000;
    end else if (accept_point & ~blocked) begin
      captured <= live;
    end else begin
      captured <= cand;
    end
  end

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cpu_irq_req_out <= 1'b0;
      cpu_irq_vec_out <= `VEC_NONE;
      cpu_irq_at_break_out <= 1'b0;
    end else if (take) begin
      cpu_irq_req_out <= 1'b1;
      cpu_irq_vec_out <= win_vec;
      cpu_irq_at_break_out <= cpu_block_break_in & block_move_word_count_in;
    end else if (cpu_ack_in) begin
      cpu_irq_req_out <= 1'b0;
      cpu_irq_at_break_out <= 1'b0;
    end
  end

  // ==========================================================
  // Control-register instruction effects
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      block_next <= 1'b0;
      global_mask <= `RST_GLOBAL_MASK;
      mask_pend <= `RST_GLOBAL_MASK;
    end else begin
      // Held until the boundary that follows the control instruction
      if (cpu_ctrl_insn_in) begin
        block_next <= 1'b1;
      end else if (cpu_insn_end_in) begin
        block_next <= 1'b0;
      end
      if (cpu_ctrl_insn_in) begin
        mask_pend <= cpu_ctrl_mask_in;
      end
      if (cpu_ctrl_insn_in & ~cpu_ctrl_mask_in) begin
        global_mask <= 1'b0;
      end else if (mask_done) begin
        global_mask <= mask_pend;
      end
    end
  end

  // ==========================================================
  // Source flags
  assign wr_hit_ext = wr_hit(reg_wr_in, reg_addr_in, `ADDR_EXT_STATUS);
  // Only bits seen as one by an earlier read can be cleared by a zero
  assign ext_clear = wr_hit_ext ? (ext_read_seen & ~reg_wdata_in) : 16'h0000;
  assign int_clear = (wr_hit(reg_wr_in, reg_addr_in, `ADDR_INT_STATUS) ? reg_wdata_in[7:0]
                     : 8'h00) | (xfer_access_in & `XFER_CLEAR_SOURCES);

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ext_pin_flag <= 16'h0000;
      ext_read_seen <= 16'h0000;
      level_prev <= 16'h0000;
      pin_select_prev <= `RST_PIN_SELECT;
      int_flag <= 8'h00;
      nmi_flag <= 1'b0;
      nmi_prev <= 1'b0;
    end else begin
      level_prev <= sel_level;
      pin_select_prev <= irq_pin_select_reg;
      nmi_prev <= nmi_level;
      // A new edge wins over a clear in the same cycle
      ext_pin_flag <= (ext_pin_flag & ~ext_clear) | pin_rise;
      if (reg_rd_in & (reg_addr_in == `ADDR_EXT_STATUS)) begin
        ext_read_seen <= ext_pin_flag;
      end else begin
        ext_read_seen <= ext_read_seen & ~ext_clear;
      end
      int_flag <= (int_flag & ~int_clear) | int_src_in;
      if (nmi_rise) begin
        nmi_flag <= 1'b1;
      end else if (take & (win_vec == `VEC_NMI)) begin
        nmi_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Event status and interrupt output
  // Event order matches the status register layout
  assign evt_set = {nmi_rise, sel_edge, dropped, take};
  assign evt_clear = wr_hit(reg_wr_in, reg_addr_in, `ADDR_EVT_STATUS) ? reg_wdata_in[3:0]
                     : 4'h0;
  assign irq_out = |(evt_status & evt_mask);

  // ==========================================================
  // Register port
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ext_enable <= `RST_EXT_ENABLE;
      irq_pin_select_reg <= `RST_PIN_SELECT;
      int_enable <= `RST_INT_ENABLE;
      dma_claims_source <= `RST_DMA_CLAIM;
      dtu_select <= `RST_DTU_SELECT;
      evt_mask <= `RST_EVT_MASK;
      evt_status <= 4'h0;
    end else begin
      evt_status <= (evt_status & ~evt_clear) | evt_set;
      if (reg_wr_in) begin
        case (reg_addr_in)
          `ADDR_EXT_ENABLE: ext_enable <= reg_wdata_in;
          `ADDR_PIN_SELECT: irq_pin_select_reg <= reg_wdata_in;
          `ADDR_INT_ENABLE: int_enable <= reg_wdata_in[7:0];
          `ADDR_DMA_CLAIM: dma_claims_source <= reg_wdata_in[7:0];
          `ADDR_DTU_SELECT: dtu_select <= reg_wdata_in[7:0];
          `ADDR_EVT_MASK: evt_mask <= reg_wdata_in[3:0];
          default: ;
        endcase
      end
    end
  end

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `ADDR_EXT_STATUS: reg_rdata_out <= ext_pin_flag;
        `ADDR_EXT_ENABLE: reg_rdata_out <= ext_enable;
        `ADDR_PIN_SELECT: reg_rdata_out <= irq_pin_select_reg;
        `ADDR_INT_STATUS: reg_rdata_out <= {8'h00, int_flag};
        `ADDR_INT_ENABLE: reg_rdata_out <= {8'h00, int_enable};
        `ADDR_DMA_CLAIM: reg_rdata_out <= {8'h00, dma_claims_source};
        `ADDR_DTU_SELECT: reg_rdata_out <= {8'h00, dtu_select};
        `ADDR_CONTROL: reg_rdata_out <= {12'h000, cpu_irq_req_out, refuse_busy | mask_busy,
                                         block_next, global_mask};
        `ADDR_EVT_STATUS: reg_rdata_out <= {12'h000, evt_status};
        `ADDR_EVT_MASK: reg_rdata_out <= {12'h000, evt_mask};
        default: reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

endmodule // interrupt_acceptance_timing

// ==== tb/irq_accept_checker.sv ====
`include "irq_accept_defs.vh"
// ==========================================================
// Request timing checks at the CPU side
module irq_accept_checker (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic cpu_insn_end_in,
  input wire logic cpu_ctrl_insn_in,
  input wire logic block_move_byte_count_in,
  input wire logic block_move_word_count_in,
  input wire logic cpu_block_break_in,
  input wire logic cpu_ack_in,
  input wire logic cpu_irq_req_out,
  input wire logic [4:0] cpu_irq_vec_out,
  input wire logic cpu_irq_at_break_out,
  input wire logic [7:0] dtu_start_out,
  input wire logic [7:0] dma_start_out
);
  wire move_on = block_move_byte_count_in || block_move_word_count_in;
  wire at_break = cpu_block_break_in && block_move_word_count_in;
  wire accept_pt = (cpu_insn_end_in && !move_on) || at_break;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_ctrl_end;
    cpu_ctrl_insn_in && cpu_insn_end_in && !cpu_irq_req_out;
  endsequence
  sequence s_refused;
    !cpu_irq_req_out [*4];
  endsequence
  refuse_window_a: assert property (s_ctrl_end |=> s_refused)
    else $error("request presented inside the refusal window");
  present_point_a: assert property ($rose(cpu_irq_req_out) |-> $past(accept_pt))
    else $error("request presented away from an accept point");
  request_hold_a: assert property (cpu_irq_req_out && !cpu_ack_in |=>
    cpu_irq_req_out && $stable(cpu_irq_vec_out))
    else $error("request or vector changed before acknowledge");
  ack_release_a: assert property (cpu_irq_req_out && cpu_ack_in |=> !cpu_irq_req_out)
    else $error("request held after acknowledge");
  byte_move_a: assert property (block_move_byte_count_in |=> !$rose(cpu_irq_req_out))
    else $error("request taken during byte-count move");
  break_flag_a: assert property ($rose(cpu_irq_req_out) |->
    cpu_irq_at_break_out == $past(at_break))
    else $error("break flag does not match accept point");
  claim_split_a: assert property ((dma_start_out & dtu_start_out) == 8'h00)
    else $error("claimed source also starts transfer unit");
  vec_valid_a: assert property ($rose(cpu_irq_req_out) |-> cpu_irq_vec_out != `VEC_NONE)
    else $error("request presented without a vector");
endmodule // irq_accept_checker

// ==== tb/cpu_core_model.sv ====
// ==========================================================
// Instruction stream and exception acknowledge of the core
module cpu_core_model (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic cpu_irq_req_in,
  input wire logic [3:0] ack_wait_in,
  output logic insn_end_out,
  output logic ctrl_insn_out,
  output logic ctrl_mask_out,
  output logic byte_move_out,
  output logic word_move_out,
  output logic block_break_out,
  output logic ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  initial begin
    {insn_end_out, ctrl_insn_out, ctrl_mask_out} = 3'h0;
    {byte_move_out, word_move_out, block_break_out} = 3'h0;
  end
  // Acknowledge only while a request stands, after a chosen delay
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_cnt <= 4'h0;
      ack_out <= 1'b0;
    end else if (ack_out || !cpu_irq_req_in) begin
      ack_out <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt == ack_wait_in) begin
      ack_out <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
  task automatic insn(input logic ctrl, input logic mask);
    @(posedge ref_clk_in);
    insn_end_out <= 1'b1;
    ctrl_insn_out <= ctrl;
    ctrl_mask_out <= mask;
    @(posedge ref_clk_in);
    insn_end_out <= 1'b0;
    ctrl_insn_out <= 1'b0;
  endtask
  // A word move stops when a request is taken at a break
  task automatic move(input logic word, input int n);
    logic stop;
    stop = 1'b0;
    @(posedge ref_clk_in);
    byte_move_out <= !word;
    word_move_out <= word;
    for (int i = 0; i < n && !stop; i++) begin
      @(posedge ref_clk_in);
      block_break_out <= 1'b1;
      @(posedge ref_clk_in);
      block_break_out <= 1'b0;
      @(posedge ref_clk_in);
      stop = word && cpu_irq_req_in;
    end
    byte_move_out <= 1'b0;
    word_move_out <= 1'b0;
    insn_end_out <= !stop;
    @(posedge ref_clk_in);
    insn_end_out <= 1'b0;
  endtask
endmodule // cpu_core_model

// ==== tb/test_interrupt_acceptance_timing.sv ====
`include "irq_accept_defs.vh"
// ==========================================================
// Register and request sequences against the controller
module test_interrupt_acceptance_timing;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, nmi = 0;
  logic [3:0] addr = 0;
  logic [15:0] wdata = 0, pin = 16'h0008, alt = 16'h0020, rdata;
  logic [7:0] src = 0, xacc = 0, dtu, dma;
  logic iend, cins, cmask, bmv, wmv, brk, ack, req, at_brk, irq;
  logic [4:0] vec;
  int fail_count = 0, n_checks = 0;
  always #4 clk = ~clk;
  interrupt_acceptance_timing dut (.ref_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .ext_pin_request_in(pin), .ext_pin_alt_in(alt), .nmi_pin_in(nmi), .int_src_in(src),
    .xfer_access_in(xacc), .cpu_insn_end_in(iend), .cpu_ctrl_insn_in(cins),
    .cpu_ctrl_mask_in(cmask), .block_move_byte_count_in(bmv), .block_move_word_count_in(wmv),
    .cpu_block_break_in(brk), .cpu_ack_in(ack), .cpu_irq_req_out(req), .cpu_irq_vec_out(vec),
    .cpu_irq_at_break_out(at_brk), .dtu_start_out(dtu), .dma_start_out(dma), .irq_out(irq));
  cpu_core_model cpu (.ref_clk_in(clk), .rstn_in(rstn), .cpu_irq_req_in(req),
    .ack_wait_in(4'h3), .insn_end_out(iend), .ctrl_insn_out(cins), .ctrl_mask_out(cmask),
    .byte_move_out(bmv), .word_move_out(wmv), .block_break_out(brk), .ack_out(ack));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
  endtask
  task automatic clr_ext(input int n);
    rd_chk(`ADDR_EXT_STATUS, 16'h0001 << n, 16'h0001 << n);
    wr_reg(`ADDR_EXT_STATUS, ~(16'h0001 << n));
  endtask
  task automatic pin_edge(input int n);
    @(posedge clk);
    pin[n] <= 1'b1;
    repeat (5) @(posedge clk);
    pin[n] <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic wait_req(input logic [4:0] ev, input logic eb);
    for (int i = 0; i < 40 && req !== 1'b1; i++) @(negedge clk);
    chk({9'h0, req, at_brk, vec}, {9'h0, 1'b1, eb, ev});
    for (int i = 0; i < 20 && req !== 1'b0; i++) @(negedge clk);
  endtask
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) @(negedge clk) seen = seen | req;
    chk({15'h0, seen}, 16'h0000);
  endtask
  initial begin
    #40000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(`ADDR_CONTROL, 16'hffff, 16'h0001);
    rd_chk(`ADDR_EXT_STATUS, 16'hffff, 16'h0008);
    clr_ext(3);
    rd_chk(`ADDR_EXT_STATUS, 16'hffff, 16'h0000);
    wr_reg(4'hf, 16'hffff);
    rd_chk(4'hf, 16'hffff, 16'h0000);
    wr_reg(`ADDR_EXT_ENABLE, 16'h0007);
    wr_reg(`ADDR_EVT_MASK, 16'h0001);
    cpu.insn(1'b1, 1'b0);
    cpu.insn(1'b0, 1'b0);
    pin_edge(2);
    wr_reg(`ADDR_EXT_ENABLE, 16'h0003);
    cpu.insn(1'b0, 1'b0);
    wait_req(5'h02, 1'b0);
    clr_ext(2);
    wr_reg(`ADDR_EXT_ENABLE, 16'h0007);
    wr_reg(`ADDR_EVT_STATUS, 16'h000f);
    cpu.insn(1'b0, 1'b0);
    pin_edge(2);
    pin_edge(1);
    wr_reg(`ADDR_EXT_ENABLE, 16'h0003);
    cpu.insn(1'b0, 1'b0);
    wait_req(5'h01, 1'b0);
    rd_chk(`ADDR_EVT_STATUS, 16'h0003, 16'h0003);
    chk({15'h0, irq}, 16'h0001);
    wr_reg(`ADDR_EVT_STATUS, 16'h000f);
    chk({15'h0, irq}, 16'h0000);
    cpu.insn(1'b1, 1'b1);
    clr_ext(1);
    clr_ext(2);
    cpu.insn(1'b0, 1'b0);
    quiet(8);
    rd_chk(`ADDR_EVT_STATUS, 16'h0002, 16'h0000);
    cpu.insn(1'b1, 1'b0);
    wr_reg(`ADDR_INT_ENABLE, 16'h0001);
    cpu.insn(1'b0, 1'b0);
    @(posedge clk) src <= 8'h01;
    @(posedge clk) src <= 8'h00;
    wr_reg(`ADDR_INT_STATUS, 16'h0001);
    cpu.insn(1'b0, 1'b0);
    wait_req(`VEC_INT_BASE, 1'b0);
    wr_reg(`ADDR_INT_ENABLE, 16'h0010);
    wr_reg(`ADDR_DMA_CLAIM, 16'h0010);
    wr_reg(`ADDR_DTU_SELECT, 16'h0010);
    @(posedge clk) src <= 8'h10;
    @(posedge clk) src <= 8'h00;
    @(negedge clk) chk({dtu, dma}, 16'h0010);
    cpu.insn(1'b0, 1'b0);
    quiet(8);
    @(posedge clk) xacc <= 8'h10;
    @(posedge clk) xacc <= 8'h00;
    rd_chk(`ADDR_INT_STATUS, 16'h0010, 16'h0000);
    wr_reg(`ADDR_DMA_CLAIM, 16'h0000);
    pin_edge(0);
    cpu.move(1'b0, 4);
    wait_req(5'h00, 1'b0);
    clr_ext(0);
    pin_edge(0);
    cpu.move(1'b1, 6);
    wait_req(5'h00, 1'b1);
    cpu.insn(1'b1, 1'b1);
    clr_ext(0);
    cpu.insn(1'b1, 1'b0);
    cpu.insn(1'b0, 1'b0);
    cpu.move(1'b1, 6);
    quiet(8);
    fork
      cpu.insn(1'b1, 1'b1);
      begin
        rd_chk(`ADDR_CONTROL, 16'h0001, 16'h0000);
        rd_chk(`ADDR_CONTROL, 16'h0001, 16'h0000);
        rd_chk(`ADDR_CONTROL, 16'h0001, 16'h0001);
      end
    join
    @(posedge clk) nmi <= 1'b1;
    repeat (5) @(posedge clk);
    cpu.insn(1'b0, 1'b0);
    quiet(6);
    cpu.insn(1'b0, 1'b0);
    wait_req(`VEC_NMI, 1'b0);
    @(posedge clk) nmi <= 1'b0;
    wr_reg(`ADDR_EVT_STATUS, 16'h000b);
    wr_reg(`ADDR_EXT_ENABLE, 16'h0000);
    wr_reg(`ADDR_PIN_SELECT, 16'h0020);
    repeat (5) @(posedge clk);
    rd_chk(`ADDR_EXT_STATUS, 16'h0020, 16'h0020);
    rd_chk(`ADDR_EVT_STATUS, 16'h0004, 16'h0004);
    chk({15'h0, irq}, 16'h0000);
    wr_reg(`ADDR_EVT_MASK, 16'h0004);
    chk({15'h0, irq}, 16'h0001);
    wr_reg(`ADDR_EVT_STATUS, 16'h0004);
    chk({15'h0, irq}, 16'h0000);
    clr_ext(5);
    rd_chk(`ADDR_EXT_STATUS, 16'h0020, 16'h0000);
    tally_and_finish();
  end
endmodule // test_interrupt_acceptance_timing
bind interrupt_acceptance_timing irq_accept_checker chk_u (.ref_clk_in, .rstn_in,
  .cpu_insn_end_in, .cpu_ctrl_insn_in, .block_move_byte_count_in, .block_move_word_count_in,
  .cpu_block_break_in, .cpu_ack_in, .cpu_irq_req_out, .cpu_irq_vec_out, .cpu_irq_at_break_out,
  .dtu_start_out, .dma_start_out);
